// ==== design/dict_consts.vh ====
`ifndef DICT_CONSTS_VH
`define DICT_CONSTS_VH

// Byte offsets on the register bus
`define DICT_OFF_RUN 6'h00
`define DICT_OFF_CH_BASE 6'h04
`define DICT_CH_STRIDE 6'h0c
`define DICT_SUB_CSR 6'h00
`define DICT_SUB_CNT 6'h04
`define DICT_SUB_PER 6'h08
`define DICT_OFF_IRQ_STAT 6'h1c
`define DICT_OFF_IRQ_MASK 6'h20
`define DICT_OFF_STANDBY 6'h24

// Channel control/status field positions
`define DICT_CSR_FLAG 7
`define DICT_CSR_IRQ_EN 6
`define DICT_CSR_XFER_EN 5
`define DICT_CSR_CKS_HI 1
`define DICT_CSR_CKS_LO 0

// Reset values
`define DICT_CNT_RST 16'h0000
`define DICT_PER_RST 16'hffff
`define DICT_STANDBY_RST 1'b0

// Clock select codes
`define DICT_CKS_DIV8 2'h0
`define DICT_CKS_DIV32 2'h1
`define DICT_CKS_DIV128 2'h2
`define DICT_CKS_DIV512 2'h3

// Prescaler masks, one less than each division
`define DICT_MASK_DIV8 9'h007
`define DICT_MASK_DIV32 9'h01f
`define DICT_MASK_DIV128 9'h07f
`define DICT_MASK_DIV512 9'h1ff

`endif

// ==== design/dict_timer.v ====
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "dict_consts.vh"

module dict_timer (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  // Avalon-MM slave
  input wire [5:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  output wire [31:0] o_readdata,
  output wire o_waitrequest,
  // Interrupts
  output wire o_irq,
  output wire [1:0] o_match_irq,
  // Transfer controller
  output wire o_xfer_req,
  output wire o_xfer_chan,
  input wire i_xfer_clear
);

  reg wait_r;
  reg [31:0] rdata_r;
  reg [1:0] run_r;
  reg standby_r;
  reg [1:0] stat_r;
  reg [1:0] mask_r;
  reg irq_r;
  reg [1:0] match_irq_r;
  reg xfer_req_r;
  reg xfer_chan_r;
  reg [8:0] pre_r;
  reg [31:0] rdata_nxt;

  wire t2_wr;
  wire t2_rd;
  wire [31:0] ch_cnt;
  wire [31:0] ch_per;
  wire [15:0] ch_csr;
  wire [1:0] ch_match;
  wire [1:0] ch_pend;
  wire [1:0] ch_xen;

  // Divided clock pulse for a select code
  function div_tick;
    input [1:0] cks;
    input [8:0] pre;
    reg [8:0] m;
    begin
      m = `DICT_MASK_DIV512;
      if (cks == `DICT_CKS_DIV8)
      begin
        m = `DICT_MASK_DIV8;
      end
      else if (cks == `DICT_CKS_DIV32)
      begin
        m = `DICT_MASK_DIV32;
      end
      else if (cks == `DICT_CKS_DIV128)
      begin
        m = `DICT_MASK_DIV128;
      end
      div_tick = ((pre & m) == m);
    end
  endfunction

  // Address of a channel register
  function [5:0] ch_addr;
    input ch;
    input [5:0] sub;
    begin
      ch_addr = `DICT_OFF_CH_BASE + (ch ? `DICT_CH_STRIDE : 6'h00) + sub;
    end
  endfunction

  assign t2_wr = i_write & ~wait_r;
  assign t2_rd = i_read & ~wait_r;

  // Bus handshake: one wait cycle, then the second state
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      if ((i_read | i_write) & wait_r)
      begin
        wait_r <= 1'b0;
        rdata_r <= rdata_nxt;
      end
      else
      begin
        wait_r <= 1'b1;
      end
    end
  end

  // Read data decode
  always @*
  begin
    rdata_nxt = 32'h00000000;
    if (i_address == `DICT_OFF_RUN)
    begin
      rdata_nxt = {30'h00000000, run_r};
    end
    else if (i_address == ch_addr(1'b0, `DICT_SUB_CSR))
    begin
      rdata_nxt = {24'h000000, ch_csr[7:0]};
    end
    else if (i_address == ch_addr(1'b0, `DICT_SUB_CNT))
    begin
      rdata_nxt = {16'h0000, ch_cnt[15:0]};
    end
    else if (i_address == ch_addr(1'b0, `DICT_SUB_PER))
    begin
      rdata_nxt = {16'h0000, ch_per[15:0]};
    end
    else if (i_address == ch_addr(1'b1, `DICT_SUB_CSR))
    begin
      rdata_nxt = {24'h000000, ch_csr[15:8]};
    end
    else if (i_address == ch_addr(1'b1, `DICT_SUB_CNT))
    begin
      rdata_nxt = {16'h0000, ch_cnt[31:16]};
    end
    else if (i_address == ch_addr(1'b1, `DICT_SUB_PER))
    begin
      rdata_nxt = {16'h0000, ch_per[31:16]};
    end
    else if (i_address == `DICT_OFF_IRQ_STAT)
    begin
      rdata_nxt = {30'h00000000, stat_r};
    end
    else if (i_address == `DICT_OFF_IRQ_MASK)
    begin
      rdata_nxt = {30'h00000000, mask_r};
    end
    else if (i_address == `DICT_OFF_STANDBY)
    begin
      rdata_nxt = {31'h00000000, standby_r};
    end
  end

  // Shared control, prescaler, interrupt and transfer logic
  always @(posedge i_clock)
  begin
    if (i_srst)
    begin
      run_r <= 2'h0;
      standby_r <= `DICT_STANDBY_RST;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      irq_r <= 1'b0;
      match_irq_r <= 2'h0;
      xfer_req_r <= 1'b0;
      xfer_chan_r <= 1'b0;
      pre_r <= 9'h000;
    end
    else
    begin
      if (!standby_r)
      begin
        pre_r <= pre_r + 9'h001;
      end
      if (t2_wr && i_byteenable[0] && i_address == `DICT_OFF_RUN)
      begin
        run_r <= i_writedata[1:0];
      end
      if (t2_wr && i_byteenable[0] && i_address == `DICT_OFF_STANDBY)
      begin
        standby_r <= i_writedata[0];
      end
      if (t2_wr && i_byteenable[0] && i_address == `DICT_OFF_IRQ_MASK)
      begin
        mask_r <= i_writedata[1:0];
      end
      if (t2_wr && i_byteenable[0] && i_address == `DICT_OFF_IRQ_STAT)
      begin
        stat_r <= (stat_r & ~i_writedata[1:0]) | ch_match;
      end
      else
      begin
        stat_r <= stat_r | ch_match;
      end
      // Interrupt level and transfer request
      irq_r <= |(stat_r & mask_r);
      match_irq_r <= ch_pend & ~ch_xen;
      xfer_req_r <= |(ch_pend & ch_xen);
      xfer_chan_r <= ~(ch_pend[0] & ch_xen[0]);
    end
  end

  // Per-channel counter, period and control/status
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ch
      reg [15:0] cnt_r;
      reg [15:0] per_r;
      reg [1:0] cks_r;
      reg irq_en_r;
      reg xfer_en_r;
      reg flag_r;
      reg seen_r;
      reg [15:0] cnt_nxt;
      wire tick;
      wire match;
      wire cnt_wr;
      wire csr_wr;
      wire flag_clr;
      wire per_wr;
      wire flag_rd;

      // Channel strobes
      assign tick = run_r[gi] & ~standby_r & div_tick(cks_r, pre_r);
      assign match = tick & (cnt_r == per_r);
      assign cnt_wr = t2_wr & (i_address == ch_addr(gi == 1, `DICT_SUB_CNT));
      assign csr_wr = t2_wr & i_byteenable[0] & (i_address == ch_addr(gi == 1, `DICT_SUB_CSR));
      assign per_wr = t2_wr & (i_address == ch_addr(gi == 1, `DICT_SUB_PER));
      assign flag_rd = t2_rd & flag_r & (i_address == ch_addr(gi == 1, `DICT_SUB_CSR));
      assign flag_clr = (csr_wr & seen_r & ~i_writedata[`DICT_CSR_FLAG])
        | (i_xfer_clear & xfer_req_r & (xfer_chan_r == gi));

      // Counter next value with write contention
      always @*
      begin
        cnt_nxt = cnt_r;
        if (match)
        begin
          cnt_nxt = `DICT_CNT_RST;
        end
        else if (cnt_wr)
        begin
          if (i_byteenable[0])
          begin
            cnt_nxt[7:0] = i_writedata[7:0];
          end
          if (i_byteenable[1])
          begin
            cnt_nxt[15:8] = i_writedata[15:8];
          end
        end
        else if (tick)
        begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end

      always @(posedge i_clock)
      begin
        if (i_srst)
        begin
          cnt_r <= `DICT_CNT_RST;
          per_r <= `DICT_PER_RST;
          cks_r <= `DICT_CKS_DIV8;
          irq_en_r <= 1'b0;
          xfer_en_r <= 1'b0;
          flag_r <= 1'b0;
          seen_r <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          if (per_wr)
          begin
            if (i_byteenable[0])
            begin
              per_r[7:0] <= i_writedata[7:0];
            end
            if (i_byteenable[1])
            begin
              per_r[15:8] <= i_writedata[15:8];
            end
          end
          if (csr_wr)
          begin
            cks_r <= i_writedata[`DICT_CSR_CKS_HI:`DICT_CSR_CKS_LO];
            irq_en_r <= i_writedata[`DICT_CSR_IRQ_EN];
            xfer_en_r <= i_writedata[`DICT_CSR_XFER_EN];
          end
          // Set wins over clear
          if (match)
          begin
            flag_r <= 1'b1;
          end
          else if (flag_clr)
          begin
            flag_r <= 1'b0;
          end
          // Read of a set flag arms its clear
          if (csr_wr)
          begin
            seen_r <= 1'b0;
          end
          else if (flag_rd)
          begin
            seen_r <= 1'b1;
          end
        end
      end

      assign ch_cnt[16 * gi +: 16] = cnt_r;
      assign ch_per[16 * gi +: 16] = per_r;
      assign ch_csr[8 * gi +: 8] = {flag_r, irq_en_r, xfer_en_r, 3'h0, cks_r};
      assign ch_match[gi] = match;
      assign ch_pend[gi] = flag_r & irq_en_r;
      assign ch_xen[gi] = xfer_en_r;
    end
  endgenerate

  assign o_readdata = rdata_r;
  assign o_waitrequest = wait_r;
  assign o_irq = irq_r;
  assign o_match_irq = match_irq_r;
  assign o_xfer_req = xfer_req_r;
  assign o_xfer_chan = xfer_chan_r;

endmodule

// ==== tb/dict_timer_sva.sv ====
`timescale 1ns/1ps
module dict_timer_chk (
  // Clock and reset
  input wire i_clock,
  input wire i_srst,
  // Bus
  input wire [5:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] o_readdata,
  input wire o_waitrequest,
  // Events
  input wire o_irq,
  input wire [1:0] o_match_irq,
  input wire o_xfer_req,
  input wire o_xfer_chan,
  input wire i_xfer_clear
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  wait_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low twice");
  wait_answer_a: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("access not answered");
  wait_idle_a: assert property (
    o_waitrequest && !i_read && !i_write |=> o_waitrequest)
    else $error("answer without request");
  unmapped_zero_a: assert property (
    i_read && o_waitrequest && i_address == 6'h28 |=> o_readdata == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (
    disable iff (1'b0) i_srst |=> o_waitrequest && !o_irq && o_match_irq == 2'h0 && !o_xfer_req)
    else $error("outputs active after reset");
  irq_fall_a: assert property (
    $fell(o_irq) |-> $past(i_write, 2) || $past(i_write, 3))
    else $error("irq dropped without write");
  match_fall_a: assert property (
    $fell(o_match_irq[0]) |-> $past(i_write, 2) || $past(i_write, 3))
    else $error("match irq dropped without write");
  xfer_split_a: assert property (o_xfer_req |-> !o_match_irq[o_xfer_chan])
    else $error("served channel also interrupts");
  xfer_fall_a: assert property (
    $fell(o_xfer_req) |-> $past(i_xfer_clear, 2) || $past(i_write, 2) || $past(i_write, 3))
    else $error("transfer request dropped");
endmodule
bind dict_timer dict_timer_chk i_chk (.i_clock(i_clock), .i_srst(i_srst), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_irq(o_irq), .o_match_irq(o_match_irq), .o_xfer_req(o_xfer_req),
  .o_xfer_chan(o_xfer_chan), .i_xfer_clear(i_xfer_clear));

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic i_clock = 0, i_srst = 1, i_read = 0, i_write = 0, i_xfer_clear = 0;
  logic [5:0] i_address = 0;
  logic [31:0] i_writedata = 0, o_readdata, d, h;
  logic [3:0] i_byteenable = 0;
  logic [3:0] be = 4'h3;
  logic o_waitrequest, o_irq, o_xfer_req, o_xfer_chan;
  logic [1:0] o_match_irq;
  int errors = 0, check_count = 0, cyc = 0, n;
  dict_timer i_dut (.i_clock(i_clock), .i_srst(i_srst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_irq(o_irq), .o_match_irq(o_match_irq), .o_xfer_req(o_xfer_req),
    .o_xfer_chan(o_xfer_chan), .i_xfer_clear(i_xfer_clear));
  initial forever #5 i_clock = ~i_clock;
  task report_and_stop;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge i_clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors++;
      report_and_stop;
    end
  end
  task chk(string s, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task acc(bit w, logic [5:0] a, logic [31:0] v);
    i_read <= !w;
    i_write <= w;
    i_address <= a;
    i_writedata <= v;
    i_byteenable <= be;
    @(posedge i_clock);
    while (o_waitrequest !== 1'b0)
      @(posedge i_clock);
    d = o_readdata;
    i_read <= 0;
    i_write <= 0;
    @(posedge i_clock);
  endtask
  task wt(bit s);
    n = 0;
    while ((s ? o_xfer_req : o_match_irq[0]) !== 1'b1 && n < 90)
    begin
      @(posedge i_clock);
      n++;
    end
  endtask
  task pulse;
    i_xfer_clear <= 1;
    @(posedge i_clock);
    i_xfer_clear <= 0;
    repeat (3) @(posedge i_clock);
  endtask
  task t_reset;
    acc(0, 6'h08, 0);
    chk("cnt0", 32'h0, d);
    acc(0, 6'h18, 0);
    chk("per1", 32'hffff, d);
    acc(0, 6'h28, 0);
    chk("unmapped", 32'h0, d);
  endtask
  task t_rate;
    for (int k = 0; k < 4; k++)
    begin
      acc(1, 6'h04, k);
      acc(1, 6'h08, 0);
      acc(1, 6'h00, 1);
      repeat (64 << (3 + 2 * k)) @(posedge i_clock);
      acc(1, 6'h00, 0);
      acc(0, 6'h08, 0);
      chk("rate", 32'h1, d[15:0] - 16'h40 <= 16'h1);
    end
    h = d;
    repeat (100) @(posedge i_clock);
    acc(0, 6'h08, 0);
    chk("halt", h, d);
    acc(1, 6'h24, 1);
    acc(1, 6'h00, 1);
    repeat (600) @(posedge i_clock);
    acc(0, 6'h08, 0);
    chk("standby", h, d);
    acc(1, 6'h00, 0);
    acc(1, 6'h24, 0);
  endtask
  task t_match;
    acc(1, 6'h04, 32'h40);
    acc(1, 6'h0c, 3);
    acc(1, 6'h08, 0);
    acc(1, 6'h20, 1);
    acc(1, 6'h00, 1);
    wt(0);
    chk("late", 32'h1, n >= 22 && n < 45);
    repeat (2) @(posedge i_clock);
    chk("irq", 32'h1, o_irq);
    acc(1, 6'h00, 0);
    acc(0, 6'h08, 0);
    chk("wrap", 32'h1, d[15:0] <= 16'h3);
    acc(1, 6'h04, 32'hc0);
    acc(0, 6'h04, 0);
    chk("flag_w1", 32'h1, d[7]);
    acc(1, 6'h04, 32'h40);
    repeat (3) @(posedge i_clock);
    chk("mirq_clr", 32'h0, o_match_irq[0]);
    acc(1, 6'h20, 0);
    repeat (3) @(posedge i_clock);
    chk("masked", 32'h0, o_irq);
    acc(1, 6'h20, 1);
    repeat (3) @(posedge i_clock);
    chk("sticky", 32'h1, o_irq);
    acc(1, 6'h1c, 1);
    repeat (3) @(posedge i_clock);
    chk("w1c", 32'h0, o_irq);
  endtask
  task t_xfer;
    acc(1, 6'h04, 32'h60);
    acc(1, 6'h10, 32'h60);
    acc(1, 6'h0c, 1);
    acc(1, 6'h18, 1);
    acc(1, 6'h08, 0);
    acc(1, 6'h14, 0);
    acc(1, 6'h00, 3);
    wt(1);
    acc(1, 6'h00, 0);
    chk("chan0", 32'h0, o_xfer_chan);
    chk("suppr", 32'h0, o_match_irq);
    pulse;
    chk("chan1", 32'h1, {o_xfer_req, o_xfer_chan} == 2'h3);
    pulse;
    chk("done", 32'h0, o_xfer_req);
  endtask
  // Writes aimed at tick edges, phased from the match edge (ticks every 8 cycles)
  task t_race;
    acc(1, 6'h04, 32'h40);
    acc(1, 6'h0c, 2);
    acc(1, 6'h08, 0);
    acc(1, 6'h00, 1);
    wt(0);
    chk("race_sync", 32'h1, n < 90);
    repeat (4) @(posedge i_clock);
    acc(1, 6'h08, 32'h1234);
    acc(0, 6'h08, 0);
    chk("word_race", 32'h1234, d);
    repeat (10) @(posedge i_clock);
    be = 4'h2;
    acc(1, 6'h08, 32'hab00);
    be = 4'h3;
    acc(0, 6'h08, 0);
    chk("byte_race", 32'hab35, d);
    acc(1, 6'h08, 1);
    repeat (7) @(posedge i_clock);
    acc(1, 6'h08, 32'h5555);
    acc(0, 6'h08, 0);
    chk("match_race", 32'h0, d);
    acc(1, 6'h04, 32'h40);
    acc(0, 6'h04, 0);
    chk("no_read_clr", 32'h1, d[7]);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_srst <= 0;
    @(posedge i_clock);
    t_reset;
    t_rate;
    t_match;
    t_xfer;
    t_race;
    report_and_stop;
  end
endmodule
